// >>> logic/activation_detect.sv
/*
  Activation detector: turns the selected source into a one-cycle event or a level request.
  Assumes timer and serial events come from the same clock; the request pin is asynchronous.
*/
`timescale 1ns/1ps
module activation_detect
  import dma_chb_pkg::*;
(
  input  wire logic       clk,          // System clock.
  input  wire logic       rst_n,        // Synchronised active-low reset.
  input  wire logic       req_pin_n,    // External transfer request pin, asynchronous.
  input  wire logic [3:0] timer_evt,    // Timer compare/capture A pulses.
  input  wire logic       tx_empty_evt, // Serial transmit-empty pulse.
  input  wire logic       rx_full_evt,  // Serial receive-full pulse.
  input  wire act_src_t   source,       // Decoded activation source.
  output logic            edge_evt,     // One-cycle event from an edge-type source.
  output logic            level_req     // Standing request from a level-type source.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Three-stage pin synchroniser and filtered level.
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff; // Synchroniser chain.
  logic level_ff;                        // Accepted pin level.
  logic nxt_level;                       // Next accepted level.
  logic pin_fall;                        // Accepted high-to-low change.

  // The level changes only when the second and third stages agree.
  always_comb begin
    nxt_level = (pin_s2_ff == pin_s3_ff) ? pin_s3_ff : level_ff;
    pin_fall  = level_ff & ~nxt_level;
  end

  // Registers the chain; the pin idles high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      level_ff  <= 1'b1;
    end else begin
      pin_s1_ff <= req_pin_n;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      level_ff  <= nxt_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source selection.

  // Picks the event or level that the decoded source names.
  always_comb begin
    edge_evt  = 1'b0;
    level_req = 1'b0;
    case (source)
      SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_TIMER3: begin
        edge_evt = timer_evt[source[1:0]]; // (RULE1) (RULE7)
      end
      SRC_TX_EMPTY:   edge_evt  = tx_empty_evt; // (RULE1)
      SRC_RX_FULL:    edge_evt  = rx_full_evt; // (RULE1)
      SRC_PIN_FALL:   edge_evt  = pin_fall; // (RULE2) (RULE6)
      SRC_PIN_LOW:    level_req = ~level_ff; // (RULE2) (RULE6)
      SRC_AUTO_BURST: level_req = 1'b1; // (RULE6)
      SRC_AUTO_STEAL: level_req = 1'b1; // (RULE6)
      default: begin
        edge_evt  = 1'b0;
        level_req = 1'b0;
      end
    endcase
  end

endmodule : activation_detect

// >>> logic/dma_channel_b_control.sv
/*
  Channel B control of the first DMA controller: registers, activation and address stepping.
  Assumes a memory bus that answers each request with a one-cycle acknowledge.
  // Summary of operation
  // (RULE1) Short mode codes: timers, serial empty/full.
  // (RULE2) Codes 110/111: pin falling edge, pin low.
  // (RULE3) Interrupt when enabled and transfer enable clear.
  // (RULE4) Short mode steps address by size, direction.
  // (RULE5) Transfers only while transfer enable set.
  // (RULE6) Full normal: burst, cycle-steal, pin codes only.
  // (RULE7) Full block: timers or pin falling edge.
  // (RULE8) Block-area select: destination 0, source 1.
  // (RULE9) Full mode steps address only when enabled.
  // (RULE10) Peripheral address used in short mode only.
  // (RULE11) Full mode master enable gates transfers.
  // (RULE12) Block mode: size part plus block counter.
  // (RULE13) Reset leaves control bits all zero.
*/
`timescale 1ns/1ps
module dma_channel_b_control
  import dma_chb_pkg::*;
(
  input  wire logic       clk,          // System clock, 200 MHz.
  input  wire logic       reset_n,      // Asynchronous active-low reset.
  input  wire logic [7:0] reg_addr,     // Register byte offset.
  input  wire logic [7:0] reg_wdata,    // Register write data.
  input  wire logic       reg_wr,       // Write strobe.
  input  wire logic       reg_rd,       // Read strobe.
  output logic      [7:0] reg_rdata,    // Read data, valid the cycle after the strobe.
  input  wire logic       req_pin_n,    // External transfer request pin.
  input  wire logic [3:0] timer_evt,    // Timer compare/capture A pulses.
  input  wire logic       tx_empty_evt, // Serial transmit-empty pulse.
  input  wire logic       rx_full_evt,  // Serial receive-full pulse.
  output logic            xfer_valid,   // Transfer request to the memory bus.
  output xfer_cmd_t       xfer_cmd,     // Addresses and size of the request.
  input  wire logic       xfer_ack,     // Memory bus has done the transfer.
  output logic            cpu_irq,      // Transfer-end interrupt to the CPU.
  output logic            irq           // Level interrupt from enabled status bits.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic rst_meta_ff, rst_n; // Two-stage release of the reset.

  // Asserts at once, releases after two clock edges.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State declarations.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Waiting for an activation.
    ST_BUSY = 2'b01   // Request out, waiting for the acknowledge.
  } eng_state_t;

  eng_state_t  state_ff, nxt_state;       // Engine state.
  logic [23:0] addr_ff, nxt_addr;         // Memory address.
  logic [23:0] base_ff, nxt_base;         // Start address for reloads.
  logic [15:0] count_ff, nxt_count;       // Transfer count.
  logic [7:0]  size_init_ff, nxt_size_init; // Reload value of the block size in block mode.
  logic [7:0]  periph_ff, nxt_periph;     // Peripheral address.
  logic [7:0]  ctl_ff, nxt_ctl;           // Transfer control.
  logic [1:0]  mode_ff, nxt_mode;         // Full and block mode bits.
  logic [EVT_WIDTH-1:0] status_ff, nxt_status; // Sticky events.
  logic [EVT_WIDTH-1:0] irq_en_ff, nxt_irq_en; // Interrupt enables.
  logic [EVT_WIDTH-1:0] evt_set;          // Events raised this cycle.
  logic        pend_ff, nxt_pend;         // Edge activation waiting to be served.
  xfer_cmd_t   cmd_ff, nxt_cmd;           // Request being presented.

  logic        full_mode, block_mode;     // Decoded mode bits.
  logic        enabled;                   // Channel allowed to transfer.
  logic        has_work;                  // Count leaves something to transfer.
  logic        edge_evt, level_req;       // Activation from the detector.
  act_src_t    source;                    // Decoded activation source.
  op_mode_t    op;                        // Short-mode operation.
  logic        step_on;                   // Address steps after this transfer.
  logic [23:0] stepped;                   // Address after a step.

  // Adds or subtracts one byte or one word from an address.
  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic down,
                                            input logic word);
    logic [23:0] d;
    d = word ? STEP_WORD : STEP_BYTE;
    return down ? (a - d) : (a + d);
  endfunction : step_addr

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and activation.

  // Works out mode, operation, enable and whether any count remains.
  always_comb begin
    full_mode  = mode_ff[MODE_FULL];
    block_mode = mode_ff[MODE_FULL] & mode_ff[MODE_BLOCK];
    source     = decode_source(full_mode, block_mode, ctl_ff[CTL_SEL_HI:0]);
    enabled    = ctl_ff[CTL_ENABLE]; // (RULE5) (RULE11)
    if (!ctl_ff[CTL_REPEAT]) begin
      op = OP_IO; // (RULE3)
    end else if (ctl_ff[CTL_IRQ]) begin
      op = OP_IDLE; // (RULE3)
    end else begin
      op = OP_REPEAT; // (RULE3)
    end
    if (block_mode) begin
      has_work = (count_ff[15:8] != 8'h00) && (count_ff[7:0] != 8'h00);
    end else if (!full_mode && op != OP_IO) begin
      has_work = count_ff[7:0] != 8'h00;
    end else begin
      has_work = count_ff != 16'h0000;
    end
    // Idle mode keeps the address; full mode steps only when allowed.
    if (full_mode) begin
      step_on = ctl_ff[CTL_REPEAT]; // (RULE9)
    end else begin
      step_on = op != OP_IDLE; // (RULE4)
    end
    stepped = step_addr(addr_ff, ctl_ff[CTL_DIR], full_mode ? 1'b0 : ctl_ff[CTL_SIZE]); // (RULE4)
    // In full mode the size bit belongs to channel A; byte steps are assumed.
  end

  activation_detect u_activation (
    .clk          (clk),
    .rst_n        (rst_n),
    .req_pin_n    (req_pin_n),
    .timer_evt    (timer_evt),
    .tx_empty_evt (tx_empty_evt),
    .rx_full_evt  (rx_full_evt),
    .source       (source),
    .edge_evt     (edge_evt),
    .level_req    (level_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and transfer engine.

  // Computes every register and engine value for the next cycle.
  always_comb begin
    nxt_state     = state_ff;
    nxt_addr      = addr_ff;
    nxt_base      = base_ff;
    nxt_count     = count_ff;
    nxt_size_init = size_init_ff;
    nxt_periph    = periph_ff;
    nxt_ctl       = ctl_ff;
    nxt_mode      = mode_ff;
    nxt_irq_en    = irq_en_ff;
    nxt_cmd       = cmd_ff;
    evt_set       = '0;
    // A new edge is kept while busy and cleared in the next idle cycle, served or not; the event wins over the clear.
    nxt_pend      = (pend_ff & ~(state_ff == ST_IDLE)) | edge_evt;

    // Software writes.
    if (reg_wr) begin
      case (reg_addr)
        OFS_ADDR_EXT:   nxt_addr[23:16] = reg_wdata;
        OFS_ADDR_HIGH:  nxt_addr[15:8]  = reg_wdata;
        OFS_ADDR_LOW:   nxt_addr[7:0]   = reg_wdata;
        OFS_COUNT_HIGH: begin
          nxt_count[15:8] = reg_wdata;
          nxt_size_init   = reg_wdata; // (RULE12)
        end
        OFS_COUNT_LOW:  nxt_count[7:0]  = reg_wdata;
        OFS_PERIPH:     nxt_periph      = reg_wdata;
        OFS_CONTROL:    nxt_ctl         = reg_wdata;
        OFS_MODE:       nxt_mode        = reg_wdata[1:0];
        OFS_IRQ_EN:     nxt_irq_en      = reg_wdata[EVT_WIDTH-1:0];
        default:        nxt_ctl         = nxt_ctl;
      endcase
      if (reg_addr >= OFS_ADDR_EXT && reg_addr <= OFS_ADDR_LOW) begin
        nxt_base = nxt_addr;
      end
    end

    case (state_ff)
      ST_IDLE: begin
        // Start when enabled, work remains and the source asks.
        if (enabled && has_work && (pend_ff || level_req)) begin // (RULE5) (RULE11)
          nxt_state         = ST_BUSY;
          nxt_cmd.mem_addr  = addr_ff;
          nxt_cmd.periph_addr = {PERIPH_PAGE, periph_ff}; // (RULE10)
          nxt_cmd.word      = ctl_ff[CTL_SIZE];
          nxt_cmd.full_mode = full_mode;
          nxt_cmd.block_src = block_mode & ctl_ff[CTL_IRQ]; // (RULE8)
          if (full_mode) begin
            nxt_cmd.periph_addr = '0; // (RULE10)
            nxt_cmd.word        = 1'b0;
          end
        end
      end
      ST_BUSY: begin
        if (xfer_ack) begin
          nxt_state = ST_IDLE;
          if (step_on) begin
            nxt_addr = stepped; // (RULE4) (RULE9)
          end
          if (block_mode) begin
            // One activation moves a whole block.
            nxt_count[15:8] = count_ff[15:8] - ONE_BYTE; // (RULE12)
            if (count_ff[15:8] == ONE_BYTE) begin
              nxt_count[15:8]    = size_init_ff; // (RULE12)
              nxt_count[7:0]     = count_ff[7:0] - ONE_BYTE; // (RULE12)
              evt_set[EVT_BLOCK] = 1'b1;
              if (!ctl_ff[CTL_IRQ]) begin
                nxt_addr = base_ff; // (RULE8)
              end
              if (count_ff[7:0] == ONE_BYTE) begin
                evt_set[EVT_END] = 1'b1;
              end
            end else begin
              nxt_state = ST_BUSY;
            end
          end else if (!full_mode && op != OP_IO) begin
            nxt_count[7:0] = count_ff[7:0] - ONE_BYTE;
            if (count_ff[7:0] == ONE_BYTE) begin
              nxt_count[7:0]   = count_ff[15:8];
              nxt_addr         = base_ff;
              evt_set[EVT_END] = 1'b1;
            end
          end else begin
            nxt_count = count_ff - ONE_WORD;
            if (count_ff == ONE_WORD) begin
              evt_set[EVT_END] = 1'b1;
              if (!full_mode) begin
                nxt_ctl[CTL_ENABLE] = 1'b0; // (RULE3) (RULE5)
              end
            end else if (source == SRC_AUTO_BURST) begin
              nxt_state = ST_BUSY; // Burst keeps the bus until the count runs out.
            end
          end
          if (nxt_state == ST_BUSY) begin
            nxt_cmd.mem_addr = nxt_addr;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    // Sticky status: a new event wins over a clear in the same cycle.
    nxt_status = status_ff;
    if (reg_wr && reg_addr == OFS_CLEAR) begin
      nxt_status = status_ff & ~reg_wdata[EVT_WIDTH-1:0];
    end
    nxt_status = nxt_status | evt_set;
  end

  // Registers the engine and the register file.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ST_IDLE;
      addr_ff      <= '0;
      base_ff      <= '0;
      count_ff     <= '0;
      size_init_ff <= '0;
      periph_ff    <= '0;
      ctl_ff       <= CONTROL_RESET; // (RULE13)
      mode_ff      <= '0; // (RULE13)
      status_ff    <= '0;
      irq_en_ff    <= '0;
      pend_ff      <= 1'b0;
      cmd_ff       <= '0;
    end else begin
      state_ff     <= nxt_state;
      addr_ff      <= nxt_addr;
      base_ff      <= nxt_base;
      count_ff     <= nxt_count;
      size_init_ff <= nxt_size_init;
      periph_ff    <= nxt_periph;
      ctl_ff       <= nxt_ctl;
      mode_ff      <= nxt_mode;
      status_ff    <= nxt_status;
      irq_en_ff    <= nxt_irq_en;
      pend_ff      <= nxt_pend;
      cmd_ff       <= nxt_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port.
  logic [7:0] rdata_ff, nxt_rdata; // Read data register.

  // Selects the addressed register; unmapped and write-only offsets read as zero.
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_ADDR_TOP:   nxt_rdata = ADDR_TOP_BITS;
        OFS_ADDR_EXT:   nxt_rdata = addr_ff[23:16];
        OFS_ADDR_HIGH:  nxt_rdata = addr_ff[15:8];
        OFS_ADDR_LOW:   nxt_rdata = addr_ff[7:0];
        OFS_COUNT_HIGH: nxt_rdata = count_ff[15:8];
        OFS_COUNT_LOW:  nxt_rdata = count_ff[7:0];
        OFS_PERIPH:     nxt_rdata = periph_ff;
        OFS_CONTROL:    nxt_rdata = ctl_ff;
        OFS_MODE:       nxt_rdata = {6'h00, mode_ff};
        OFS_STATUS:     nxt_rdata = {6'h00, status_ff};
        OFS_IRQ_EN:     nxt_rdata = {6'h00, irq_en_ff};
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  // Holds read data for the cycle after the strobe only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Drives the request, the data and both interrupt levels.
  always_comb begin
    reg_rdata  = rdata_ff;
    xfer_valid = state_ff == ST_BUSY;
    xfer_cmd   = cmd_ff;
    cpu_irq    = ~full_mode & ctl_ff[CTL_IRQ] & ~ctl_ff[CTL_ENABLE]; // (RULE3)
    irq        = |(status_ff & irq_en_ff);
  end

endmodule : dma_channel_b_control

// >>> logic/dma_chb_pkg.sv
/*
  Shared constants, types and decode functions for the channel B control block.
  Assumes an 8-bit register port with byte offsets and one 200 MHz clock.
*/
package dma_chb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_ADDR_TOP   = 8'h28;  // Memory address, bits 31:24.
  localparam logic [7:0] OFS_ADDR_EXT   = 8'h29;  // Memory address, bits 23:16.
  localparam logic [7:0] OFS_ADDR_HIGH  = 8'h2a;  // Memory address, bits 15:8.
  localparam logic [7:0] OFS_ADDR_LOW   = 8'h2b;  // Memory address, bits 7:0.
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h2c;  // Transfer count, high byte.
  localparam logic [7:0] OFS_COUNT_LOW  = 8'h2d;  // Transfer count, low byte.
  localparam logic [7:0] OFS_PERIPH     = 8'h2e;  // Peripheral address.
  localparam logic [7:0] OFS_CONTROL    = 8'h2f;  // Transfer control.
  localparam logic [7:0] OFS_MODE       = 8'h30;  // Address mode selection.
  localparam logic [7:0] OFS_STATUS     = 8'h31;  // Sticky event status, read only.
  localparam logic [7:0] OFS_CLEAR      = 8'h32;  // Status clear, write only.
  localparam logic [7:0] OFS_IRQ_EN     = 8'h33;  // Interrupt enable.

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the transfer control register.
  localparam int CTL_ENABLE = 7;  // Transfer enable, or master enable in full mode.
  localparam int CTL_SIZE   = 6;  // Word size when set.
  localparam int CTL_DIR    = 5;  // Step down when set.
  localparam int CTL_REPEAT = 4;  // Repeat enable, or step enable in full mode.
  localparam int CTL_IRQ    = 3;  // Interrupt enable, or block-area select in full mode.
  localparam int CTL_SEL_HI = 2;  // Top bit of the activation select field.
  localparam int MODE_FULL  = 0;  // Full address mode when set.
  localparam int MODE_BLOCK = 1;  // Block transfer mode when set (full mode only).
  localparam int EVT_END    = 0;  // Status bit: transfer count exhausted.
  localparam int EVT_BLOCK  = 1;  // Status bit: one block finished.
  localparam int EVT_WIDTH  = 2;  // Number of status bits.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed figures.
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  ADDR_TOP_BITS = 8'hff;    // Unused address byte reads as ones.
  localparam logic [15:0] PERIPH_PAGE   = 16'hffff; // Page that holds peripheral space.
  localparam logic [23:0] STEP_BYTE     = 24'h000001;
  localparam logic [23:0] STEP_WORD     = 24'h000002;
  localparam logic [7:0]  ONE_BYTE      = 8'h01;
  localparam logic [15:0] ONE_WORD      = 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  // Activation sources after decoding the select code against the mode.
  typedef enum logic [3:0] {
    SRC_TIMER0     = 4'h0,
    SRC_TIMER1     = 4'h1,
    SRC_TIMER2     = 4'h2,
    SRC_TIMER3     = 4'h3,
    SRC_TX_EMPTY   = 4'h4,
    SRC_RX_FULL    = 4'h5,
    SRC_PIN_FALL   = 4'h6,
    SRC_PIN_LOW    = 4'h7,
    SRC_AUTO_BURST = 4'h8,
    SRC_AUTO_STEAL = 4'h9,
    SRC_NONE       = 4'hf
  } act_src_t;

  // Short-mode operation chosen by repeat and interrupt enable.
  typedef enum logic [1:0] {
    OP_IO     = 2'b00,
    OP_REPEAT = 2'b01,
    OP_IDLE   = 2'b10
  } op_mode_t;

  // One transfer request handed to the memory bus.
  typedef struct packed {
    logic [23:0] mem_addr;    // Memory address of this transfer.
    logic [23:0] periph_addr; // Peripheral address, short mode only.
    logic        word;        // Word size when set, byte otherwise.
    logic        full_mode;   // Request belongs to full address mode.
    logic        block_src;   // Block area is the source when set.
  } xfer_cmd_t;

  // Maps mode and select code to a source; unavailable codes give SRC_NONE.
  function automatic act_src_t decode_source(input logic full, input logic block,
                                             input logic [2:0] code);
    act_src_t src;
    src = SRC_NONE;
    if (!full) begin
      src = act_src_t'({1'b0, code}); // (RULE1) (RULE2)
    end else if (block) begin
      if (!code[2]) begin
        src = act_src_t'({2'b00, code[1:0]}); // (RULE7)
      end else if (code == 3'b110) begin
        src = SRC_PIN_FALL; // (RULE7)
      end
    end else begin
      case (code) // (RULE6)
        3'b000:  src = SRC_AUTO_BURST;
        3'b010:  src = SRC_AUTO_STEAL;
        3'b110:  src = SRC_PIN_FALL;
        3'b111:  src = SRC_PIN_LOW;
        default: src = SRC_NONE;
      endcase
    end
    return src;
  endfunction : decode_source

endpackage : dma_chb_pkg

// >>> testbench/dma_chb_chk.sv
/* Checker for the channel B control block, bound to its top module.
   Assumes one clock domain and the active-low reset at the top ports. */
`timescale 1ns/1ps
module dma_chb_chk
  import dma_chb_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic       xfer_valid,
  input wire xfer_cmd_t  xfer_cmd,
  input wire logic       xfer_ack,
  input wire logic       cpu_irq,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A request stands unchanged until the bus acknowledges it.
  hold_req_a: assert property (xfer_valid && !xfer_ack |=> xfer_valid && $stable(xfer_cmd))
    else $error("request dropped or changed before acknowledge");
  page_a: assert property (xfer_valid && !xfer_cmd.full_mode |-> xfer_cmd.periph_addr[23:8] == 16'hffff)
    else $error("short mode peripheral address off the peripheral page");
  full_byte_a: assert property (xfer_valid && xfer_cmd.full_mode |-> !xfer_cmd.word)
    else $error("full mode request not byte sized");
  short_gap_a: assert property (xfer_valid && xfer_ack && !xfer_cmd.full_mode |=> !xfer_valid)
    else $error("short mode request without idle cycle");
  start_off_a: assert property ($rose(xfer_valid) && !xfer_cmd.full_mode |-> !cpu_irq)
    else $error("short transfer started while interrupt shows disabled");
  cpu_cause_a: assert property ($rose(cpu_irq) |-> $past(xfer_ack) || $past(reg_wr))
    else $error("transfer-end interrupt without end or write");
  irq_cause_a: assert property ($rose(irq) |-> $past(xfer_ack) || $past(reg_wr))
    else $error("interrupt rose without event or write");
  reset_quiet_a: assert property ($rose(reset_n) |-> !xfer_valid && !cpu_irq && !irq && reg_rdata == 8'h00)
    else $error("outputs active at reset release");
  cover property (xfer_valid && xfer_ack && xfer_cmd.full_mode);
  cover property (xfer_valid && xfer_cmd.block_src);
  cover property ($rose(irq));
endmodule : dma_chb_chk
bind dma_channel_b_control dma_chb_chk u_chk (.*);

// >>> testbench/mem_bus_model.sv
/* Memory bus responder for the channel B bench.
   Assumes one clock; acknowledges each request after a random stall of 0 to 3 cycles. */
`timescale 1ns/1ps
module mem_bus_model (
  input  wire logic clk,
  input  wire logic xfer_valid,
  output logic      xfer_ack
);
  int unsigned wait_ff = 0;  // Cycles still to stall before the next acknowledge.
  initial xfer_ack = 1'b0;
  // One-cycle acknowledge per request, slow or prompt at random.
  always @(posedge clk) begin
    if (xfer_ack) begin
      xfer_ack <= 1'b0;
    end else if (xfer_valid && wait_ff == 0) begin
      xfer_ack <= 1'b1;
      wait_ff  <= $urandom % 4;
    end else if (xfer_valid) begin
      wait_ff <= wait_ff - 1;
    end
  end
endmodule : mem_bus_model

// >>> testbench/tb_top.sv
/* Self-checking bench: register port, short, full and block transfers of channel B.
   Assumes the package and design files are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import dma_chb_pkg::*;
  logic       clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, req_pin_n = 1;
  logic       tx_empty_evt = 0, rx_full_evt = 0, xfer_valid, xfer_ack, cpu_irq, irq;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, per, ctl;
  logic [3:0] timer_evt = 0;
  logic [23:0] base;
  logic       sz, dir, ie;
  xfer_cmd_t  xfer_cmd, got, want;
  xfer_cmd_t  exp_q[$];  // Transfers the model expects, oldest first.
  int         err_total = 0, compares = 0, cyc = 0;
  dma_channel_b_control dut (.*);
  mem_bus_model pm (.*);
  always #2.5 clk = ~clk;
  task automatic conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk); reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk); reg_rd <= 1; reg_addr <= a;
    @(posedge clk); reg_rd <= 0;
    #1 chk(reg_rdata & m, e);
  endtask : rd
  task automatic seta(input logic [23:0] b);
    wr(8'h29, b[23:16]); wr(8'h2a, b[15:8]); wr(8'h2b, b[7:0]);
  endtask : seta
  task automatic fire(input int c);
    @(posedge clk);
    if (c < 4) timer_evt <= 4'h1 << c;
    tx_empty_evt <= (c == 4); rx_full_evt <= (c == 5); req_pin_n <= (c < 6);
    @(posedge clk); timer_evt <= 0; tx_empty_evt <= 0; rx_full_evt <= 0;
  endtask : fire
  task automatic done;
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(exp_q.size(), 0);
  endtask : done
  // Every acknowledged transfer is compared with the model; a stray one mismatches.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin err_total++; conclude(); end
    else if (xfer_valid === 1'b1 && xfer_ack === 1'b1) begin
      got = xfer_cmd;
      want = exp_q.size() ? exp_q.pop_front() : '1;
      chk(got, want);
    end
  end
  initial begin
    void'($urandom(60828));
    repeat (8) @(posedge clk);
    reset_n <= 1;
    repeat (4) @(posedge clk);
    rd(8'h2f, 8'h00, 8'hff);
    rd(8'h28, 8'hff, 8'hff);
    rd(8'h40, 8'h00, 8'hff);
    // Short mode: every select code with random size, direction and addresses.
    for (int c = 0; c < 8; c++) begin
      base = $urandom; per = $urandom; {sz, dir, ie} = 3'($urandom);
      seta(base); wr(8'h2e, per); wr(8'h2c, 0); wr(8'h2d, 1);
      exp_q.push_back('{base, {16'hffff, per}, sz, 1'b0, 1'b0});
      ctl = {1'b1, sz, dir, 1'b0, ie, 3'(c)};
      wr(8'h2f, ctl);
      fire(c);
      done();
      req_pin_n <= 1;
      base = 24'(dir ? base - (sz ? 2 : 1) : base + (sz ? 2 : 1));
      rd(8'h29, base[23:16], 8'hff); rd(8'h2a, base[15:8], 8'hff); rd(8'h2b, base[7:0], 8'hff);
      rd(8'h2f, ctl & 8'h7f, 8'hff);
      chk(cpu_irq, ie);
      rd(8'h31, 8'h01, 8'h01);
      wr(8'h33, 8'h01); #1 chk(irq, 1);
      wr(8'h32, 8'h03); #1 chk(irq, 0);
      wr(8'h33, 8'h00);
    end
    wr(8'h2d, 8'h01); wr(8'h2f, 8'h04); fire(4); done();
    // Full normal mode: auto burst, refused code, cycle-steal; stepping random.
    wr(8'h30, 8'h01);
    for (int c = 0; c < 3; c++) begin
      base = $urandom; {sz, dir} = 2'($urandom); seta(base); wr(8'h2c, 0); wr(8'h2d, 2);
      for (int i = 0; i < 2 && c != 1; i++)
        exp_q.push_back('{24'(sz ? (dir ? base - i : base + i) : base), 24'h0, 1'b0, 1'b1, 1'b0});
      wr(8'h2f, {1'b1, 1'b0, dir, sz, 1'b0, 3'(c)});
      done();
      wr(8'h2f, 8'h00);
    end
    // Block mode: timer 3 starts a block of two with the block area as source.
    wr(8'h30, 8'h03); base = $urandom; seta(base); wr(8'h2c, 2); wr(8'h2d, 1);
    for (int i = 0; i < 2; i++) exp_q.push_back('{24'(base + i), 24'h0, 1'b0, 1'b1, 1'b1});
    wr(8'h2f, 8'h9b); fire(3); done();
    rd(8'h31, 8'h02, 8'h02);
    conclude();
  end
endmodule : tb_top
